// ---- logic/gpio_output_config.sv ----
`timescale 1ns/1ps
module gpio_output_config (
  // clock and reset
  input  wire logic                                ref_clk,
  input  wire logic                                reset,
  // register port
  input  wire logic [gpio_cfg_pkg::ADDR_W-1:0]     regAddr,
  input  wire logic                                regWrite,
  input  wire logic                                regRead,
  input  wire logic [gpio_cfg_pkg::REG_W-1:0]      regWdata,
  output logic      [gpio_cfg_pkg::REG_W-1:0]      regRdata,
  output logic                                     regRvalid,
  // pins
  input  wire logic [gpio_cfg_pkg::PIN_COUNT-1:0]  pinIn,
  output logic      [gpio_cfg_pkg::PIN_COUNT-1:0]  pinOut,
  output logic      [gpio_cfg_pkg::PIN_COUNT-1:0]  pinOe,
  output logic      [gpio_cfg_pkg::PIN_COUNT-1:0]  pinLevel
);

  localparam int NB = gpio_cfg_pkg::BANK_COUNT;
  localparam int RW = gpio_cfg_pkg::REG_W;
  localparam int NP = gpio_cfg_pkg::PIN_COUNT;

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic [RW-1:0] level_q [NB];
  logic [RW-1:0] level_d [NB];
  logic [RW-1:0] mode_q  [NB];
  logic [RW-1:0] mode_d  [NB];
  logic [RW-1:0] dir_q   [NB];
  logic [RW-1:0] dir_d   [NB];

  gpio_cfg_pkg::reg_group_t accGroup;
  logic [1:0]               accBank;
  logic [RW-1:0]            accMask;
  logic [RW-1:0]            accData;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  always_comb begin
    accGroup = gpio_cfg_pkg::groupOf(regAddr);
    accBank  = gpio_cfg_pkg::bankOf(regAddr);
    accMask  = gpio_cfg_pkg::bankMask(accBank);
    // masking at write time keeps reserved bits reading as zero
    accData  = regWdata & accMask;
  end

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  logic [NB-1:0] wrLevel;
  logic [NB-1:0] wrMode;
  logic [NB-1:0] wrDir;

  // an unmapped offset raises no strobe, so a stray write changes nothing
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      wrLevel[b] = regWrite && (accGroup == gpio_cfg_pkg::GRP_LEVEL) && (accBank == 2'(b));
      wrMode[b]  = regWrite && (accGroup == gpio_cfg_pkg::GRP_MODE) && (accBank == 2'(b));
      wrDir[b]   = regWrite && (accGroup == gpio_cfg_pkg::GRP_DIR) && (accBank == 2'(b));
    end
  end

  // ----------------------------------------------------------------
  // register next state
  // ----------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < NB; b++) begin
      level_d[b] = wrLevel[b] ? accData : level_q[b];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < NB; b++) begin
      if (reset) begin
        level_q[b] <= gpio_cfg_pkg::RST_LEVEL;
      end else begin
        level_q[b] <= level_d[b];
      end
    end
  end

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      mode_d[b] = wrMode[b] ? accData : mode_q[b];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < NB; b++) begin
      if (reset) begin
        mode_q[b] <= gpio_cfg_pkg::RST_MODE;
      end else begin
        mode_q[b] <= mode_d[b];
      end
    end
  end

  always_comb begin
    for (int b = 0; b < NB; b++) begin
      dir_d[b] = wrDir[b] ? accData : dir_q[b];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < NB; b++) begin
      if (reset) begin
        dir_q[b] <= gpio_cfg_pkg::RST_DIR;
      end else begin
        dir_q[b] <= dir_d[b];
      end
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  logic [RW-1:0] rdata_q;
  logic [RW-1:0] rdata_d;
  logic          rvalid_q;
  logic          rvalid_d;
  logic [RW-1:0] rdWord;

  // the word is picked every cycle, but only a read strobe loads it
  always_comb begin
    case (accGroup)
      gpio_cfg_pkg::GRP_LEVEL: begin
        rdWord = level_q[accBank];
      end
      gpio_cfg_pkg::GRP_MODE: begin
        rdWord = mode_q[accBank];
      end
      gpio_cfg_pkg::GRP_DIR: begin
        rdWord = dir_q[accBank];
      end
      default: begin
        rdWord = gpio_cfg_pkg::READ_ZERO;
      end
    endcase
  end

  always_comb begin
    rdata_d  = rdata_q;
    rvalid_d = regRead;
    if (regRead) begin
      rdata_d = rdWord;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_q  <= gpio_cfg_pkg::READ_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign regRdata  = rdata_q;
  assign regRvalid = rvalid_q;

  // ----------------------------------------------------------------
  // bank to pin mapping
  // ----------------------------------------------------------------
  pin_drive_if pins ();

  // pin p+1 sits in bank p/8 at bit p%8; the third bank holds only
  // pins 17 to 19, so its upper bits never reach a driver
  function automatic int bankOfPin(input int p);
    bankOfPin = p / RW;
  endfunction : bankOfPin

  function automatic int bitOfPin(input int p);
    bitOfPin = p % RW;
  endfunction : bitOfPin

  for (genvar p = 0; p < NP; p++) begin : gMap
    localparam int PinBank = bankOfPin(p);
    localparam int PinBit  = bitOfPin(p);

    assign pins.level[p] = level_q[PinBank][PinBit];
    assign pins.mode[p]  = mode_q[PinBank][PinBit];
    assign pins.dir[p]   = dir_q[PinBank][PinBit];
  end

  pin_driver uDriver (
    .pins (pins.drv)
  );

  // ----------------------------------------------------------------
  // pin registers
  // ----------------------------------------------------------------
  logic [NP-1:0] pinOut_q;
  logic [NP-1:0] pinOut_d;
  logic [NP-1:0] pinOe_q;
  logic [NP-1:0] pinOe_d;
  logic [NP-1:0] pinLevel_q;
  logic [NP-1:0] pinLevel_d;

  // one cycle of latency after the register write, traded for clean outputs
  always_comb begin
    pinOut_d   = pins.drvOut;
    pinOe_d    = pins.drvOe;
    // input sample only; it never feeds back into the drivers
    pinLevel_d = pinIn;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinOut_q   <= '0;
      pinOe_q    <= '0;
      pinLevel_q <= '0;
    end else begin
      pinOut_q   <= pinOut_d;
      pinOe_q    <= pinOe_d;
      pinLevel_q <= pinLevel_d;
    end
  end

  assign pinOut   = pinOut_q;
  assign pinOe    = pinOe_q;
  assign pinLevel = pinLevel_q;

endmodule : gpio_output_config

// ---- shared/gpio_cfg_pkg.sv ----
package gpio_cfg_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int REG_W          = 8;
  localparam int BANK_COUNT     = 3;
  localparam int PIN_COUNT      = 19;
  localparam int ADDR_W         = 8;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_LEVEL_A = 8'h2a;
  localparam logic [7:0] OFF_LEVEL_B = 8'h2b;
  localparam logic [7:0] OFF_LEVEL_C = 8'h2c;
  localparam logic [7:0] OFF_MODE_A  = 8'h2d;
  localparam logic [7:0] OFF_MODE_B  = 8'h2e;
  localparam logic [7:0] OFF_MODE_C  = 8'h2f;
  localparam logic [7:0] OFF_DIR_A   = 8'h30;
  localparam logic [7:0] OFF_DIR_B   = 8'h31;
  localparam logic [7:0] OFF_DIR_C   = 8'h32;

  // ----------------------------------------------------------------
  // bank indices, masks, reset values, encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] BANK_A      = 2'h0;
  localparam logic [1:0] BANK_B      = 2'h1;
  localparam logic [1:0] BANK_C      = 2'h2;
  localparam logic [7:0] MASK_FULL   = 8'hff;
  localparam logic [7:0] MASK_BANK_C = 8'h07;
  localparam logic [7:0] READ_ZERO   = 8'h00;
  localparam logic [7:0] RST_LEVEL   = 8'h00;
  localparam logic [7:0] RST_MODE    = 8'h00;
  localparam logic [7:0] RST_DIR     = 8'h00;
  localparam logic       DRIVE_OPEN  = 1'h1;
  localparam logic       DIR_OUTPUT  = 1'h1;

  typedef enum logic [1:0] {GRP_NONE, GRP_LEVEL, GRP_MODE, GRP_DIR} reg_group_t;

  function automatic reg_group_t groupOf(input logic [7:0] addr);
    case (addr)
      OFF_LEVEL_A, OFF_LEVEL_B, OFF_LEVEL_C: groupOf = GRP_LEVEL;
      OFF_MODE_A, OFF_MODE_B, OFF_MODE_C:    groupOf = GRP_MODE;
      OFF_DIR_A, OFF_DIR_B, OFF_DIR_C:       groupOf = GRP_DIR;
      default:                               groupOf = GRP_NONE;
    endcase
  endfunction : groupOf

  function automatic logic [1:0] bankOf(input logic [7:0] addr);
    case (addr)
      OFF_LEVEL_A, OFF_MODE_A, OFF_DIR_A: bankOf = BANK_A;
      OFF_LEVEL_B, OFF_MODE_B, OFF_DIR_B: bankOf = BANK_B;
      default:                            bankOf = BANK_C;
    endcase
  endfunction : bankOf

  // reserved bits of the third bank never store
  function automatic logic [7:0] bankMask(input logic [1:0] bank);
    bankMask = (bank == BANK_C) ? MASK_BANK_C : MASK_FULL;
  endfunction : bankMask

endpackage : gpio_cfg_pkg

// ---- shared/pin_drive_if.sv ----
`timescale 1ns/1ps
interface pin_drive_if;
  logic [gpio_cfg_pkg::PIN_COUNT-1:0] level;
  logic [gpio_cfg_pkg::PIN_COUNT-1:0] mode;
  logic [gpio_cfg_pkg::PIN_COUNT-1:0] dir;
  logic [gpio_cfg_pkg::PIN_COUNT-1:0] drvOut;
  logic [gpio_cfg_pkg::PIN_COUNT-1:0] drvOe;

  modport cfg (output level, output mode, output dir, input drvOut, input drvOe);
  modport drv (input level, input mode, input dir, output drvOut, output drvOe);
endinterface : pin_drive_if

// ---- logic/pin_driver.sv ----
`timescale 1ns/1ps
module pin_driver (
  // per-pin configuration in, drive out
  pin_drive_if.drv pins
);

  // ----------------------------------------------------------------
  // per-pin driver
  // ----------------------------------------------------------------
  for (genvar p = 0; p < gpio_cfg_pkg::PIN_COUNT; p++) begin : gPin
    always_comb begin
      if (pins.dir[p] != gpio_cfg_pkg::DIR_OUTPUT) begin
        pins.drvOut[p] = 1'b0;
        pins.drvOe[p]  = 1'b0;
      end else if (pins.mode[p] == gpio_cfg_pkg::DRIVE_OPEN) begin
        // a released pin relies on an external pull-up for its high
        pins.drvOut[p] = 1'b0;
        pins.drvOe[p]  = ~pins.level[p];
      end else begin
        pins.drvOut[p] = pins.level[p];
        pins.drvOe[p]  = 1'b1;
      end
    end
  end

endmodule : pin_driver

// ---- dv/gpio_output_config_checker.sv ----
`timescale 1ns/1ps
module gpio_output_config_checker (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regWdata,
  input wire logic [7:0]  regRdata,
  input wire logic        regRvalid,
  // pins
  input wire logic [18:0] pinIn,
  input wire logic [18:0] pinOut,
  input wire logic [18:0] pinOe,
  input wire logic [18:0] pinLevel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // a full-width bank written, then read straight back
  sequence wr_then_rd;
    regWrite && regAddr inside {8'h2a, 8'h2b, 8'h2d, 8'h2e, 8'h30, 8'h31}
      ##1 regRead && !regWrite && regAddr == $past(regAddr);
  endsequence
  chk_read_answer: assert property (regRead |=> regRvalid)
    else $error("read not answered");
  chk_rvalid_pulse: assert property (!regRead |=> !regRvalid)
    else $error("read valid without a read");
  chk_readback_full: assert property (wr_then_rd |=> regRdata == $past(regWdata, 2))
    else $error("written value not read back");
  chk_unmapped_zero: assert property (regRead && !(regAddr inside {[8'h2a:8'h32]})
    |=> regRdata == 8'h00)
    else $error("unmapped read not zero");
  chk_bank_c_reserved: assert property (regRead && regAddr inside {8'h2c, 8'h2f, 8'h32}
    |=> regRdata[7:3] == 5'h00)
    else $error("reserved bits read nonzero");
  // bank a input pins may neither drive nor enable after a bank a direction write, whatever level and mode say
  chk_dir_a_input: assert property (regWrite && regAddr == 8'h30
    |-> ##2 ((pinOe[7:0] | pinOut[7:0]) & ~$past(regWdata, 2)) == 8'h00)
    else $error("input pin driven");
  chk_out_needs_oe: assert property ((pinOut & ~pinOe) == 19'h00000)
    else $error("high output without enable");
  chk_level_sample: assert property (!reset |=> pinLevel == $past(pinIn))
    else $error("pin level not one cycle behind");
endmodule : gpio_output_config_checker

// ---- dv/pin_pullup_load.sv ----
`timescale 1ns/1ps
module pin_pullup_load (
  // drive from the device
  input  wire logic [18:0] pinOut,
  input  wire logic [18:0] pinOe,
  // level seen on the wires
  output logic      [18:0] pinIn
);
  // a released wire floats up through the board pull-up, never holds its old value
  assign pinIn = (pinOe & pinOut) | ~pinOe;
endmodule : pin_pullup_load

// ---- dv/gpio_output_config_tb.sv ----
`timescale 1ns/1ps
module gpio_output_config_tb;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [7:0]  regWdata = 8'h00;
  logic [7:0]  regRdata;
  logic        regRvalid;
  logic [18:0] pinIn, pinOut, pinOe, pinLevel, expOut, expOe;
  logic [23:0] cfg [2][3];
  int          n_mismatch = 0;
  int          checks_done = 0;

  always #12.5 ref_clk = ~ref_clk;

  gpio_output_config uut (.ref_clk(ref_clk), .reset(reset), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata),
    .regRvalid(regRvalid), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .pinLevel(pinLevel));
  pin_pullup_load load (.pinOut(pinOut), .pinOe(pinOe), .pinIn(pinIn));

  // ----------------------------------------------------------------
  // register access and compares
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic cmp(input string what, input logic [18:0] exp, input logic [18:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  // strobe stays up so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regRead  <= 1'b0;
    regAddr  <= a;
    regWdata <= d;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    int n;
    n = 0;
    regRead  <= 1'b1;
    regWrite <= 1'b0;
    regAddr  <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(negedge ref_clk);
    while (regRvalid !== 1'b1 && n < 4) begin
      @(negedge ref_clk);
      n++;
    end
    if (regRvalid !== 1'b1) begin
      n_mismatch++;
      give_verdict();
    end else begin
      cmp("regRdata", {11'h000, exp}, {11'h000, regRdata});
      @(posedge ref_clk);
    end
  endtask : rd
  task automatic idle(input int n);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : idle

  initial begin
    // level, mode, direction per set; bank a in the low byte
    cfg = '{'{24'h05_5aa5, 24'h03_33cc, 24'h06_f00f}, '{24'h02_a55a, 24'h04_cc33, 24'h07_0ff0}};
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++) begin
      rd(8'h2a + i[7:0], 8'h00);
      wr(8'h2a + i[7:0], 8'ha5 ^ i[7:0]);
      rd(8'h2a + i[7:0], (8'ha5 ^ i[7:0]) & ((i % 3 == 2) ? 8'h07 : 8'hff));
    end
    wr(8'h29, 8'hff);
    rd(8'h29, 8'h00);
    rd(8'h33, 8'h00);
    rd(8'h2a, 8'ha5);
    for (int s = 0; s < 2; s++) begin
      for (int r = 0; r < 9; r++) wr(8'h2a + r[7:0], cfg[s][r / 3][(r % 3) * 8 +: 8]);
      idle(4);
      expOut = cfg[s][2][18:0] & ~cfg[s][1][18:0] & cfg[s][0][18:0];
      expOe  = cfg[s][2][18:0] & (~cfg[s][1][18:0] | ~cfg[s][0][18:0]);
      @(negedge ref_clk);
      cmp("pinOut", expOut, pinOut);
      cmp("pinOe", expOe, pinOe);
      cmp("pinLevel", ~expOe | expOut, pinLevel);
      @(posedge ref_clk);
    end
    // reset in mid-run must leave every driver off once it is released
    reset <= 1'b1;
    idle(2);
    reset <= 1'b0;
    @(posedge ref_clk);
    @(negedge ref_clk);
    cmp("pinOe", 19'h00000, pinOe);
    cmp("pinOut", 19'h00000, pinOut);
    @(posedge ref_clk);
    rd(8'h30, 8'h00);
    give_verdict();
  end
endmodule : gpio_output_config_tb

bind gpio_output_config gpio_output_config_checker chk (.ref_clk(ref_clk), .reset(reset),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
  .regRdata(regRdata), .regRvalid(regRvalid), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .pinLevel(pinLevel));
